/* File: hw/squib_ctl_pkg.sv */
// Purpose: shared constants and types of the squib command logic
// Assumes: 8-bit frames, four channels, 20 MHz system clock
// Notes: command codes are the frame values seen on the serial input
package squib_ctl_pkg;
   localparam int channels = 4;
   localparam logic [7:0] cmd_unlock_timer_one = 8'h80;
   localparam logic [7:0] cmd_unlock_timer_two = 8'h81;
   localparam logic [7:0] cmd_unlock_high_test = 8'h82;
   localparam logic [7:0] cmd_unlock_low_test = 8'h83;
   localparam logic [3:0] grp_meas_reset = 4'h3;
   localparam logic [3:0] grp_meas_read = 4'h7;
   localparam logic [3:0] grp_high_code = 4'h1;
   localparam logic [3:0] grp_low_code = 4'h2;
   localparam logic [7:0] cmd_comparator = 8'h79;
   localparam logic [7:0] cmd_thermal = 8'h7F;
   localparam logic [7:0] cmd_nop = 8'h00;
   localparam int clk_hz = 20_000_000;
   localparam int ms_us = 1000;
   localparam int ms_cycles = (clk_hz / 1_000_000) * ms_us;
   localparam int step_us = 10;
   localparam int step_cycles = (clk_hz / 1_000_000) * step_us;
   localparam int thermal_min_us = 2090;
   localparam int thermal_max_us = 2820;
   localparam int thermal_min_cycles = (clk_hz / 1_000_000) * thermal_min_us;
   localparam int thermal_max_cycles = (clk_hz / 1_000_000) * thermal_max_us;
   localparam logic [7:0] timer_reset = 8'h00;
   localparam logic [3:0] test_reset = 4'h0;

   typedef struct packed {
      logic [3:0] high_side;
      logic [3:0] low_side;
   } drive_type;
endpackage : squib_ctl_pkg

/* File: hw/squib_ctl.sv */
// Purpose: serial command interpreter of a four-channel squib driver
// Assumes: host is a mode-0 serial master; sclk, cs_n, mosi, pins async
// Notes: one frame is eight sclk rising edges while cs_n is low
module squib_ctl
   import squib_ctl_pkg::*;
#(
   parameter int ms_count = ms_cycles
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic fire_permit_pin_one,
   input wire logic fire_permit_pin_two,
   input wire logic [3:0] arm_fire,
   input wire logic [3:0] current_measure_threshold,
   input wire logic [3:0] fet_turned_on,
   input wire logic thermal_rearm_level,
   output logic miso,
   output logic [3:0] squib_high_output,
   output drive_type test_drive,
   output logic test_limit,
   output logic fire_permit_one,
   output logic fire_permit_two,
   output logic [3:0] thermal_shutdown
);
   typedef enum logic [2:0] {
      idle = 3'b001,
      await_timer = 3'b010,
      await_test = 3'b100
   } phase_type;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [5:0] sync_a;
   logic [5:0] sync_b;
   logic sclk_d;
   logic cs_d;
   always_ff @(posedge clk) begin
      sync_a <= {sclk, cs_n, mosi, fire_permit_pin_one, fire_permit_pin_two,
                 thermal_rearm_level};
      sync_b <= sync_a;
      sclk_d <= sync_b[5];
      cs_d <= sync_b[4];
   end
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic cs_fall;
   logic pin_one;
   logic pin_two;
   assign sclk_rise = sync_b[5] & ~sclk_d & ~sync_b[4];
   assign sclk_fall = ~sync_b[5] & sclk_d & ~sync_b[4];
   assign cs_rise = sync_b[4] & ~cs_d;
   assign cs_fall = ~sync_b[4] & cs_d;
   assign pin_one = sync_b[2];
   assign pin_two = sync_b[1];

   // ------------------------------------------------------------
   // frame shifter
   // ------------------------------------------------------------
   logic [7:0] rx;
   logic [7:0] tx;
   logic [7:0] reply;
   logic [3:0] bit_cnt;
   logic frame_done;
   assign frame_done = cs_rise && (bit_cnt == 4'd8);
   always_ff @(posedge clk) begin
      if (rst || cs_fall) begin
         bit_cnt <= 4'd0;
         rx <= 8'h00;
      end else if (sclk_rise && bit_cnt != 4'd8) begin
         rx <= {rx[6:0], sync_b[3]};
         bit_cnt <= bit_cnt + 4'd1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         tx <= 8'h00;
         miso <= 1'b0;
      end else if (cs_fall) begin
         tx <= {reply[6:0], 1'b0};
         miso <= reply[7];
      end else if (sclk_fall) begin
         tx <= {tx[6:0], 1'b0};
         miso <= tx[7];
      end
   end

   // ------------------------------------------------------------
   // command decoding
   // ------------------------------------------------------------
   phase_type phase;
   logic target_two;
   logic test_low;
   logic [7:0] delay_one;
   logic [7:0] delay_two;
   logic permits_low;
   logic firing;
   assign permits_low = ~pin_one & ~pin_two;
   assign firing = |squib_high_output;
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= idle;
         target_two <= 1'b0;
         test_low <= 1'b0;
      end else if (frame_done) begin
         case (phase)
            idle: begin
               if (rx == cmd_unlock_timer_one
                   || rx == cmd_unlock_timer_two) begin
                  phase <= await_timer;
                  target_two <= rx[0];
               end else if ((rx == cmd_unlock_high_test
                             || rx == cmd_unlock_low_test)
                            && permits_low) begin
                  phase <= await_test;
                  test_low <= rx[0];
               end
            end
            await_timer: phase <= idle;
            await_test: phase <= idle;
            default: phase <= idle;
         endcase
      end
   end

   // hold delays: unlock clears, data byte loads
   always_ff @(posedge clk) begin
      if (rst) begin
         delay_one <= timer_reset;
         delay_two <= timer_reset;
      end else if (frame_done && phase == idle) begin
         if (rx == cmd_unlock_timer_one) begin
            delay_one <= timer_reset;
         end
         if (rx == cmd_unlock_timer_two) begin
            delay_two <= timer_reset;
         end
      end else if (frame_done && phase == await_timer) begin
         if (target_two) begin
            delay_two <= rx;
         end else begin
            delay_one <= rx;
         end
      end
   end

   // ------------------------------------------------------------
   // fet self-test
   // ------------------------------------------------------------
   logic [3:0] high_fail;
   logic [3:0] low_fail;
   logic test_unlock;
   assign test_unlock = frame_done && phase == idle && permits_low
      && (rx == cmd_unlock_high_test || rx == cmd_unlock_low_test);
   always_ff @(posedge clk) begin
      if (rst || test_unlock || fire_permit_one || fire_permit_two) begin
         test_drive <= '0;
         test_limit <= 1'b0;
      end else if (frame_done && phase == await_test) begin
         if (!test_low && rx[7:4] == grp_high_code) begin
            test_drive.high_side <= rx[3:0];
            test_limit <= |rx[3:0];
         end else if (test_low && rx[7:4] == grp_low_code) begin
            test_drive.low_side <= rx[3:0];
            test_limit <= |rx[3:0];
         end
      end else if (frame_done && phase == idle && rx == cmd_nop) begin
         test_drive <= '0;
         test_limit <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || test_unlock) begin
         high_fail <= test_reset;
         low_fail <= test_reset;
      end else begin
         high_fail <= high_fail | (test_drive.high_side & ~fet_turned_on);
         low_fail <= low_fail | (test_drive.low_side & ~fet_turned_on);
      end
   end

   // ------------------------------------------------------------
   // fire permits with latch and hold
   // ------------------------------------------------------------
   logic [7:0] ms_left_one;
   logic [7:0] ms_left_two;
   logic [15:0] sub_one;
   logic [15:0] sub_two;
   logic end_one;
   logic end_two;
   logic pin_one_d;
   logic pin_two_d;
   // each pin owns its prescaler, held at zero while the pin is high,
   // so a hold never runs short by part of a millisecond
   assign end_one = sub_one == 16'(ms_count - 1);
   assign end_two = sub_two == 16'(ms_count - 1);
   always_ff @(posedge clk) begin
      if (rst || pin_one || end_one || ms_left_one == 8'h00) begin
         sub_one <= 16'h0000;
      end else begin
         sub_one <= sub_one + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || pin_two || end_two || ms_left_two == 8'h00) begin
         sub_two <= 16'h0000;
      end else begin
         sub_two <= sub_two + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_one_d <= 1'b0;
         pin_two_d <= 1'b0;
         ms_left_one <= 8'h00;
         ms_left_two <= 8'h00;
         fire_permit_one <= 1'b0;
         fire_permit_two <= 1'b0;
      end else begin
         pin_one_d <= pin_one;
         pin_two_d <= pin_two;
         if (pin_one && !pin_one_d) begin
            ms_left_one <= delay_one;
         end else if (!pin_one && end_one && ms_left_one != 8'h00) begin
            ms_left_one <= ms_left_one - 8'h01;
         end
         if (pin_two && !pin_two_d) begin
            ms_left_two <= delay_two;
         end else if (!pin_two && end_two && ms_left_two != 8'h00) begin
            ms_left_two <= ms_left_two - 8'h01;
         end
         fire_permit_one <= pin_one || ms_left_one != 8'h00;
         fire_permit_two <= pin_two || ms_left_two != 8'h00;
      end
   end

   // ------------------------------------------------------------
   // per-channel drive, thermal model and on-time
   // ------------------------------------------------------------
   logic [7:0] on_steps [channels];
   logic [15:0] on_cycles [channels];
   logic [15:0] step_cnt;
   logic step_tick;
   logic [3:0] thermal_flag;
   logic [3:0] meas_clear;
   logic thermal_report;
   assign step_tick = step_cnt == 16'(step_cycles - 1);
   assign meas_clear = (frame_done && phase == idle
      && rx[7:4] == grp_meas_reset) ? rx[3:0] : 4'h0;
   always_ff @(posedge clk) begin
      if (rst || step_tick) begin
         step_cnt <= 16'h0000;
      end else begin
         step_cnt <= step_cnt + 16'h0001;
      end
   end
   for (genvar c = 0; c < channels; c++) begin : g_ch
      always_ff @(posedge clk) begin
         if (rst) begin
            squib_high_output[c] <= 1'b0;
            thermal_shutdown[c] <= 1'b0;
            on_cycles[c] <= 16'h0000;
         end else begin
            // held off while shutdown stands and rearm level absent
            squib_high_output[c] <= arm_fire[c]
               && (fire_permit_one || fire_permit_two)
               && !thermal_shutdown[c];
            if (squib_high_output[c]
                && on_cycles[c] != 16'(thermal_max_cycles)) begin
               on_cycles[c] <= on_cycles[c] + 16'h0001;
            end else if (!squib_high_output[c]) begin
               on_cycles[c] <= 16'h0000;
            end
            // short: current above threshold in the cycle the on-time reaches the window end
            if (squib_high_output[c] && current_measure_threshold[c]
                && on_cycles[c] == 16'(thermal_max_cycles - 1)) begin
               thermal_shutdown[c] <= 1'b1;
            end else if (thermal_shutdown[c] && sync_b[0]) begin
               thermal_shutdown[c] <= 1'b0;
            end
         end
      end
      always_ff @(posedge clk) begin
         if (rst || meas_clear[c]) begin
            on_steps[c] <= 8'h00;
         end else if (squib_high_output[c] && current_measure_threshold[c]
                      && step_tick && on_steps[c] != 8'hFF) begin
            on_steps[c] <= on_steps[c] + 8'h01;
         end
      end
   end

   // thermal latch: set wins over the report clear
   always_ff @(posedge clk) begin
      if (rst) begin
         thermal_flag <= 4'h0;
      end else begin
         thermal_flag <= (thermal_report ? 4'h0 : thermal_flag)
            | thermal_shutdown;
      end
   end

   // ------------------------------------------------------------
   // reply for the next frame
   // ------------------------------------------------------------
   logic show_fail;
   always_ff @(posedge clk) begin
      if (rst) begin
         reply <= 8'h00;
         thermal_report <= 1'b0;
         show_fail <= 1'b0;
      end else if (frame_done) begin
         thermal_report <= phase == idle && rx == cmd_thermal;
         show_fail <= phase == await_test;
         if (phase == await_timer) begin
            reply <= rx;
         end else if (phase == await_test) begin
            reply <= {high_fail, low_fail};
         end else if (rx[7:2] == 6'b100000) begin
            reply <= rx;
         end else if (rx == cmd_comparator) begin
            reply <= {4'h0, current_measure_threshold};
         end else if (rx == cmd_thermal) begin
            reply <= {4'h0, thermal_flag};
         end else if (rx[7:4] == grp_meas_read) begin
            reply <= on_steps[rx[1:0]];
         end else begin
            reply <= 8'h00;
         end
      end else begin
         thermal_report <= 1'b0;
         // fail bits grow while the test runs; the next frame takes
         // whatever stands when its chip select falls
         if (show_fail) begin
            reply <= {high_fail, low_fail};
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_no_cross_drive: assert property (@(posedge clk) disable iff (rst)
      !(|test_drive.high_side && |test_drive.low_side))
      else $error("high and low test drive together");
   a_test_abort: assert property (@(posedge clk) disable iff (rst)
      fire_permit_one |=> test_drive == '0)
      else $error("test drive during firing enable");
   a_unlock_blocked: assert property (@(posedge clk) disable iff (rst)
      (frame_done && phase == idle && !permits_low) |=> phase != await_test)
      else $error("test unlock taken with permit high");
   a_data_once: assert property (@(posedge clk) disable iff (rst)
      (frame_done && phase != idle) |=> phase == idle)
      else $error("data phase lasted beyond one frame");
   a_fail_clear: assert property (@(posedge clk) disable iff (rst)
      test_unlock |=> high_fail == 4'h0 && low_fail == 4'h0)
      else $error("fail bits not cleared on unlock");
   a_echo_unlock: assert property (@(posedge clk) disable iff (rst)
      (frame_done && phase == idle && rx == cmd_unlock_timer_one)
      |=> reply == cmd_unlock_timer_one)
      else $error("unlock not echoed");
   a_step_hold: assert property (@(posedge clk) disable iff (rst)
      (!current_measure_threshold[0] && !meas_clear[0])
      |=> $stable(on_steps[0]))
      else $error("count moved below threshold");
   a_thermal_min: assert property (@(posedge clk) disable iff (rst)
      $rose(thermal_shutdown[0]) |-> on_cycles[0] >= 16'(thermal_min_cycles))
      else $error("shutdown before minimum on time");
   a_delay_zero: assert property (@(posedge clk) disable iff (rst)
      (frame_done && phase == idle && rx == cmd_unlock_timer_one)
      |=> delay_one == 8'h00)
      else $error("unlock did not clear delay");
   c_program: cover property (@(posedge clk) frame_done
      && phase == await_timer);
   c_test: cover property (@(posedge clk) |test_drive.high_side);
   c_thermal: cover property (@(posedge clk) $rose(thermal_shutdown[0]));
endmodule : squib_ctl

/* File: test/spi_host_model.sv */
// Purpose: serial master standing in for the host controller
// Assumes: mode 0, msb first, 200 ns per clock phase
// Notes: caller orders the frames; this only shapes one frame
module spi_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso,
   output logic [7:0] rx_byte,
   output logic rx_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int half_ns = 200;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      rx_byte = 8'h00;
      rx_valid = 1'b0;
   end

   // ----------------------------------------------------------------
   // one frame; nbits below 8 makes a frame the device drops, above 8 only the first 8 count
   // ----------------------------------------------------------------
   task automatic send(input logic [7:0] tx, input int nbits);
      logic [7:0] sr;
      sr = tx;
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         mosi = sr[7];
         #half_ns;
         sclk = 1'b1;
         rx_byte = {rx_byte[6:0], miso};
         sr = {sr[6:0], 1'b0};
         #half_ns;
         sclk = 1'b0;
      end
      #half_ns;
      cs_n = 1'b1;
      // released line must not keep showing the last bit
      mosi = ~mosi;
      rx_valid = 1'b1;
      #half_ns;
      rx_valid = 1'b0;
      #half_ns;
   endtask : send
endmodule : spi_host_model

/* File: test/tb_top.sv */
// Purpose: self-checking bench of the squib command interpreter
// Assumes: one millisecond shortened to 20 clocks
// Notes: replies are queued when sent and checked when they arrive
module tb_top
   import squib_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int ms_sim = 20;
   logic clk, rst, sclk, cs_n, mosi, pin_one, pin_two, rearm;
   logic miso, test_limit, permit_one, permit_two, rx_valid;
   logic [3:0] arm_fire, above, fet_on, high_out, shutdown;
   logic [7:0] rx_byte, v, m;
   drive_type test_drive;
   logic [15:0] expect_q[$];
   logic [15:0] e;
   int n_errors = 0;
   int compares = 0;

   squib_ctl #(.ms_count(ms_sim)) u_dut (.clk(clk), .rst(rst),
      .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .fire_permit_pin_one(pin_one), .fire_permit_pin_two(pin_two),
      .arm_fire(arm_fire), .current_measure_threshold(above),
      .fet_turned_on(fet_on), .thermal_rearm_level(rearm), .miso(miso),
      .squib_high_output(high_out), .test_drive(test_drive),
      .test_limit(test_limit), .fire_permit_one(permit_one),
      .fire_permit_two(permit_two), .thermal_shutdown(shutdown));
   spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .rx_byte(rx_byte), .rx_valid(rx_valid));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   task automatic check8(input logic [7:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check8

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // reply of this frame is checked under msk; msk 0 means unknown
   task automatic frame(input logic [7:0] tx, exp, msk);
      expect_q.push_back({exp & msk, msk});
      u_host.send(tx, 8);
   endtask : frame

   function automatic logic perm(input int w);
      return w ? permit_two : permit_one;
   endfunction : perm

   // hold after the pin falls must last ms milliseconds, no less
   task automatic hold_check(input int w, input int ms);
      int n;
      n = 0;
      if (w) pin_two = 1'b1; else pin_one = 1'b1;
      tick(10);
      check8({7'h0, perm(w)}, 8'h01, "permit on");
      if (w) pin_two = 1'b0; else pin_one = 1'b0;
      while (perm(w) === 1'b1 && n < 6000) begin
         tick(1);
         n++;
      end
      check8(8'((n >= ms * ms_sim) && (n <= ms * ms_sim + 8)), 8'h01,
         "hold length");
      if (n >= 6000) summarize();
   endtask : hold_check

   always @(posedge rx_valid) begin
      if (expect_q.size() == 0) begin
         n_errors++;
         $display("[FAIL] %0t reply with nothing expected", $time);
      end else begin
         e = expect_q.pop_front();
         check8(rx_byte & e[7:0], e[15:8], "reply");
      end
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      $display("[FAIL] %0t run limit reached", $time);
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {pin_one, pin_two, rearm} = 3'b001;
      {arm_fire, above, fet_on} = 12'h000;
      void'($urandom(32'h5299));
      tick(3);
      rst = 1'b0;
      tick(4);
      hold_check(0, 0);
      hold_check(1, 0);
      for (int t = 0; t < 3; t++) begin
         v = (t == 2) ? 8'h00 : 8'($urandom_range(2, 9));
         frame(8'h80 + 8'(t % 2), 8'h00, 8'h00);
         frame(v, 8'h80 + 8'(t % 2), 8'hFF);
         frame(cmd_nop, v, 8'hFF);
         hold_check(t % 2, int'(v));
      end
      expect_q.push_back(16'h0000);
      u_host.send(cmd_unlock_timer_one, 7);
      frame(8'h05, 8'h00, 8'h00);
      hold_check(0, 0);
      {pin_one, pin_two} = 2'b11;
      above = 4'b0111;
      tick(10);
      arm_fire = 4'b0011;
      // 600 sampled edges of drive hold exactly three step ticks
      tick(3 * step_cycles + 1);
      check8({4'h0, high_out}, 8'h03, "high side on");
      {arm_fire, above} = 8'h00;
      frame(8'h70, 8'h00, 8'h00);
      frame(8'h71, 8'h03, 8'hFF);
      frame(8'h72, 8'h03, 8'hFF);
      frame(cmd_nop, 8'h00, 8'hFF);
      frame(8'h31, 8'h00, 8'h00);
      frame(8'h70, 8'h00, 8'h00);
      frame(8'h71, 8'h00, 8'hFF);
      frame(cmd_nop, 8'h03, 8'hFF);
      above = 4'b0101;
      frame(cmd_comparator, 8'h00, 8'h00);
      frame(cmd_thermal, 8'h05, 8'hFF);
      above = 4'h0;
      frame(cmd_nop, 8'h00, 8'hFF);
      {pin_one, pin_two} = 2'b00;
      tick(300);
      m = 8'($urandom_range(0, 15));
      fet_on = m[3:0];
      frame(cmd_unlock_high_test, 8'h00, 8'h00);
      frame(8'h1F, cmd_unlock_high_test, 8'hFF);
      tick(5);
      check8(test_drive, 8'hF0, "high test drive");
      check8({7'h0, test_limit}, 8'h01, "test limit");
      frame(cmd_unlock_low_test, {~m[3:0], 4'h0}, 8'hFF);
      tick(5);
      check8(test_drive, 8'h00, "test stopped");
      frame(8'h2A, cmd_unlock_low_test, 8'hFF);
      tick(5);
      check8(test_drive, 8'h0A, "low test drive");
      pin_two = 1'b1;
      tick(10);
      check8(test_drive, 8'h00, "test aborted");
      pin_two = 1'b0;
      tick(300);
      pin_one = 1'b1;
      frame(cmd_unlock_high_test, 8'h00, 8'h00);
      frame(8'h1F, 8'h00, 8'h00);
      tick(5);
      check8(test_drive, 8'h00, "unlock refused");
      frame(cmd_nop, 8'h00, 8'h00);
      arm_fire = 4'hF;
      tick(20);
      rst = 1'b1;
      tick(2);
      check8({high_out, permit_one, permit_two, test_limit, miso}, 8'h00,
         "outputs in reset");
      check8(test_drive, 8'h00, "test drive in reset");
      check8({4'h0, shutdown}, 8'h00, "shutdown in reset");
      rst = 1'b0;
      {pin_one, arm_fire} = 5'h00;
      tick(4);
      hold_check(1, 0);
      tick(20);
      check8(8'(expect_q.size()), 8'h00, "replies missing");
      summarize();
   end
endmodule : tb_top
